// *** core/fts_unit.sv ***
// fault_trap_status_unit: memory-management fault classification, exception pc
// selection, interrupt arbitration, processor_status and context swap control.
// assumes the core supplies page_table_entry words for the reference being checked
// and stalls issue while issue_hold_o is high.
`timescale 1ns/1ps
module fts_unit #(
   parameter int NTRAP = 4                         // arithmetic traps reportable together
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // memory reference check
   input wire logic ref_valid_i,                   // one-cycle check request
   input wire fts_pkg::fts_access_e ref_kind_i,
   input wire logic ref_kseg_i,                    // address in kernel direct segment
   input wire logic [fts_pkg::VA_W-1:0] ref_pc_i,  // pc of referencing instruction
   input wire logic [15:0] pte1_i,                 // first-level entry low bits
   input wire logic [15:0] pte2_i,                 // second-level entry low bits
   input wire logic [15:0] pte3_i,                 // third-level entry low bits
   // arithmetic traps
   input wire logic [NTRAP-1:0] arith_trap_i,      // trapping instructions this cycle
   input wire logic [NTRAP-1:0] arith_swc_i,       // their software completion modifiers
   input wire logic [fts_pkg::VA_W-1:0] next_pc_i, // next instruction that would issue
   // synchronous traps
   input wire logic sync_cause_i,                  // causing operation in flight
   input wire logic sync_done_i,                   // causing operation completed
   input wire logic [fts_pkg::VA_W-1:0] sync_pc_i, // pc after the causing operation
   // interrupt requests, pins from outside the core domain
   input wire logic io_lo_req_i,
   input wire logic io_hi_req_i,
   input wire logic clock_req_i,
   input wire logic perf_req_i,
   input wire logic mchk_req_i,
   // status operations
   input wire logic ps_write_i,                    // rti, retsys or swpipl
   input wire fts_pkg::fts_psw_e ps_src_i,
   input wire logic [fts_pkg::PS_W-1:0] ps_wdata_i,
   // context swap
   input wire logic swap_req_i,
   input wire logic [fts_pkg::VA_W-1:0] pcb_addr_i,
   input wire logic swap_done_i,                   // memory side finished save and load
   // outputs
   output logic [fts_pkg::PS_W-1:0] processor_status_o,
   output logic dispatch_o,                        // one-cycle entry pulse
   output fts_pkg::fts_entry_e dispatch_kind_o,
   output logic [fts_pkg::VA_W-1:0] exc_pc_o,
   output logic [2:0] mm_fault_code_o,             // handler argument a1 for mm entry
   output logic software_completion_summary_o,
   output logic [2:0] int_level_o,
   output logic use_kernel_stack_o,
   output logic issue_hold_o,
   output logic swap_busy_o,
   output logic swap_align_err_o
);
   import fts_pkg::*;

   // synchronisers for interrupt pins
   logic [4:0] irq_s1_reg;
   logic [4:0] irq_s2_reg;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_s1_reg <= '0;
         irq_s2_reg <= '0;
      end else begin
         irq_s1_reg <= {mchk_req_i, perf_req_i, clock_req_i, io_hi_req_i, io_lo_req_i};
         irq_s2_reg <= irq_s1_reg;
      end
   end

   // state registers
   logic [PS_W-1:0] ps_reg;
   logic [PS_W-1:0] ps_next;
   logic dispatch_reg;
   fts_entry_e kind_reg;
   logic [VA_W-1:0] pc_reg;
   logic [2:0] code_reg;
   logic swc_reg;
   logic [2:0] lvl_reg;
   logic kstack_reg;
   logic sync_pend_reg;                            // trap cause awaiting completion
   logic swap_reg;
   logic align_reg;
   logic hold_reg;                                 // registered issue hold

   // protection check of the third-level entry
   function automatic logic prot_denied(input logic [15:0] page_table_entry, input fts_access_e k,
                                        input logic mode);
      logic rd_ok;
      logic wr_ok;
      rd_ok = (mode == MODE_USER) ? page_table_entry[PTE_URE] : page_table_entry[PTE_KRE];
      wr_ok = (mode == MODE_USER) ? page_table_entry[PTE_UWE] : page_table_entry[PTE_KWE];
      return (k == FTS_ACC_WRITE) ? !wr_ok : !rd_ok;
   endfunction

   // fault classification, walk order matters: upper levels first
   // mode bit: zero runs kernel, one runs user
   wire mode_w = ps_reg[PS_MODE_BIT];
   wire kseg_acv = ref_kseg_i && (mode_w == MODE_USER);
   wire l1_bad = !pte1_i[PTE_V];
   wire l2_bad = !pte2_i[PTE_V];
   wire l1_acv = l1_bad && !pte1_i[PTE_KRE];
   wire l2_acv = l2_bad && !pte2_i[PTE_KRE];
   wire l3_acv = prot_denied(pte3_i, ref_kind_i, mode_w);
   wire tnv_any = l1_bad || l2_bad || !pte3_i[PTE_V];
   wire for_hit = (ref_kind_i == FTS_ACC_READ) && pte3_i[PTE_FOR];
   wire foe_hit = (ref_kind_i == FTS_ACC_EXEC) && pte3_i[PTE_FOE];
   wire fow_hit = (ref_kind_i == FTS_ACC_WRITE) && pte3_i[PTE_FOW];
   wire mm_fault = ref_valid_i && (kseg_acv || tnv_any || (!ref_kseg_i &&
                   (l3_acv || for_hit || foe_hit || fow_hit)));
   // the direct segment has no page tables: only the mode check applies
   logic [2:0] code_w;
   always_comb begin
      if (kseg_acv) begin
         code_w = FC_ACV;
      end else if (l1_acv || (!l1_bad && l2_acv)) begin
         code_w = FC_ACV;
      end else if (l1_bad || l2_bad) begin
         code_w = FC_TNV;
      end else if (l3_acv) begin
         code_w = FC_ACV;
      end else if (!pte3_i[PTE_V]) begin
         code_w = FC_TNV;
      end else if (fow_hit) begin
         code_w = FC_FOW;
      end else if (for_hit) begin
         code_w = FC_FOR;
      end else begin
         code_w = FC_FOE;
      end
   end
   wire mm_hit = mm_fault && !(ref_kseg_i && !kseg_acv);

   // interrupt arbitration over the source classes
   wire [2:0] src_lvl_io_lo = irq_s2_reg[0] ? IPL_DEV_LO : IPL_ZERO;
   wire [2:0] src_lvl_io_hi = irq_s2_reg[1] ? IPL_DEV_HI : IPL_ZERO;
   wire [2:0] src_lvl_clk = irq_s2_reg[2] ? IPL_CLOCK : IPL_ZERO;
   wire [2:0] src_lvl_perf = irq_s2_reg[3] ? IPL_RT : IPL_ZERO;
   wire [2:0] src_lvl_mchk = irq_s2_reg[4] ? IPL_MCHK : IPL_ZERO;
   logic [2:0] best_lvl;
   always_comb begin
      best_lvl = src_lvl_io_lo;
      if (src_lvl_io_hi > best_lvl) best_lvl = src_lvl_io_hi;
      if (src_lvl_clk > best_lvl) best_lvl = src_lvl_clk;
      if (src_lvl_perf > best_lvl) best_lvl = src_lvl_perf;
      if (src_lvl_mchk > best_lvl) best_lvl = src_lvl_mchk;
   end
   wire int_take = best_lvl > ps_reg[IPL_W-1:0];

   // arithmetic trap summary
   wire arith_any = |arith_trap_i;
   wire swc_and = &(arith_swc_i | ~arith_trap_i);
   wire sync_take = sync_pend_reg && sync_done_i;

   // dispatch selection; faults first, then traps, then interrupts
   fts_entry_e kind_w;
   always_comb begin
      if (swap_reg) begin
         kind_w = FTS_ENT_NONE;                    // swap owns the pipeline
      end else if (mm_hit) begin
         kind_w = FTS_ENT_MM;
      end else if (arith_any) begin
         kind_w = FTS_ENT_ARITH;
      end else if (sync_take) begin
         kind_w = FTS_ENT_SYNC;
      end else if (int_take) begin
         kind_w = FTS_ENT_INT;
      end else begin
         kind_w = FTS_ENT_NONE;
      end
   end
   wire take_w = kind_w != FTS_ENT_NONE;

   // next status: exception entry or documented write only
   always_comb begin
      ps_next = ps_reg;
      if (take_w) begin
         ps_next[PS_MODE_BIT] = MODE_KERNEL;
         if (kind_w == FTS_ENT_INT) ps_next[IPL_W-1:0] = best_lvl;
      end else if (ps_write_i) begin
         if (ps_src_i == FTS_PSW_SWPIPL) begin
            ps_next[IPL_W-1:0] = ps_wdata_i[IPL_W-1:0];                // swpipl keeps mode
         end else begin
            ps_next = ps_wdata_i;
         end
      end
      // user mode forces the level field to zero
      if (ps_next[PS_MODE_BIT] == MODE_USER) ps_next[IPL_W-1:0] = IPL_ZERO;
   end

   // exception pc choice
   logic [VA_W-1:0] pc_w;
   always_comb begin
      case (kind_w)
         FTS_ENT_MM: pc_w = ref_pc_i;
         FTS_ENT_ARITH: pc_w = next_pc_i;
         FTS_ENT_SYNC: pc_w = sync_pc_i;
         default: pc_w = next_pc_i;
      endcase
   end

   wire align_bad = |(pcb_addr_i[2:0] & QW_MASK);
   // next busy value, also feeding the registered issue hold
   wire swap_next = (swap_req_i && !swap_reg) ? !align_bad : (swap_reg && !swap_done_i);

   // status and mode register; kernel at level seven after reset
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) ps_reg <= PS_RESET;
      else ps_reg <= ps_next;
   end

   // dispatch outputs, registered one cycle after the cause
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         dispatch_reg <= 1'b0;
         kind_reg <= FTS_ENT_NONE;
         pc_reg <= '0;
         lvl_reg <= IPL_ZERO;
         kstack_reg <= 1'b1;
      end else begin
         dispatch_reg <= take_w;
         kind_reg <= kind_w;
         if (take_w) pc_reg <= pc_w;
         if (take_w) lvl_reg <= ps_next[IPL_W-1:0];
         kstack_reg <= ps_next[PS_MODE_BIT] == MODE_KERNEL;
      end
   end

   // handler arguments held until the next dispatch of their own kind
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         code_reg <= FC_TNV;
         swc_reg <= 1'b0;
      end else begin
         if (kind_w == FTS_ENT_MM) code_reg <= code_w;
         if (kind_w == FTS_ENT_ARITH) swc_reg <= swc_and;
      end
   end

   // synchronous trap: hold issue from cause until the trap is taken
   // a cause in the cycle its predecessor is taken re-arms the hold: set wins
   wire sync_pend_next = sync_cause_i || (sync_pend_reg && (kind_w != FTS_ENT_SYNC));
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) sync_pend_reg <= 1'b0;
      else sync_pend_reg <= sync_pend_next;
   end

   // context swap busy and alignment report
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         swap_reg <= 1'b0;
         align_reg <= 1'b0;
      end else begin
         if (swap_req_i && !swap_reg) begin
            swap_reg <= !align_bad;
            align_reg <= align_bad;
         end else if (swap_done_i) begin
            swap_reg <= 1'b0;
         end
      end
   end

   // issue hold taken from the next values, so the pin has no gate behind its flops
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) hold_reg <= 1'b0;
      else hold_reg <= sync_pend_next || swap_next;
   end

   // outputs straight from flops
   assign processor_status_o = ps_reg;
   assign dispatch_o = dispatch_reg;
   assign dispatch_kind_o = kind_reg;
   assign exc_pc_o = pc_reg;
   assign mm_fault_code_o = code_reg;
   assign software_completion_summary_o = swc_reg;
   assign int_level_o = lvl_reg;
   assign use_kernel_stack_o = kstack_reg;
   assign issue_hold_o = hold_reg;
   assign swap_busy_o = swap_reg;
   assign swap_align_err_o = align_reg;
endmodule // fts_unit

// *** core/fts_pkg.sv ***
// fault, trap and status package: encodings, field positions and priority levels
// assumes a 64-bit virtual/program address and a single core clock
package fts_pkg;
   localparam int VA_W = 64;                       // address width
   // processor_status layout
   localparam int PS_W = 4;                        // status width
   localparam int PS_MODE_BIT = 3;                 // mode bit position
   localparam int IPL_W = 3;                       // priority field width
   localparam logic [3:0] PS_RESET = 4'h7;         // kernel, all interrupts held off
   localparam logic MODE_KERNEL = 1'b0;            // kernel encoding
   localparam logic MODE_USER = 1'b1;              // user encoding
   // mm_fault_code values
   localparam logic [2:0] FC_TNV = 3'h0;           // translation not valid
   localparam logic [2:0] FC_ACV = 3'h1;           // access violation
   localparam logic [2:0] FC_FOR = 3'h2;           // fault on read
   localparam logic [2:0] FC_FOE = 3'h3;           // fault on execute
   localparam logic [2:0] FC_FOW = 3'h4;           // fault on write
   // page_table_entry field positions
   localparam int PTE_V = 0;                       // valid
   localparam int PTE_FOR = 1;                     // fault on read
   localparam int PTE_FOW = 2;                     // fault on write
   localparam int PTE_FOE = 3;                     // fault on execute
   localparam int PTE_KRE = 8;                     // kernel_read_enable
   localparam int PTE_URE = 9;                     // user read enable
   localparam int PTE_KWE = 12;                    // kernel write enable
   localparam int PTE_UWE = 13;                    // user write enable
   // interrupt source classes and their levels
   localparam int NSRC = 4;                        // io, clock, perf counter, machine check
   localparam logic [2:0] IPL_DEV_LO = 3'h3;       // low priority devices
   localparam logic [2:0] IPL_DEV_HI = 3'h4;       // high priority devices
   localparam logic [2:0] IPL_CLOCK = 3'h5;        // clock and interprocessor
   localparam logic [2:0] IPL_RT = 3'h6;           // real time devices, perf counters
   localparam logic [2:0] IPL_MCHK = 3'h7;         // machine checks
   localparam logic [2:0] IPL_ZERO = 3'h0;         // user level
   localparam logic [2:0] QW_MASK = 3'h7;          // quadword alignment bits
   // dispatch kinds
   typedef enum logic [2:0] {FTS_ENT_NONE, FTS_ENT_MM, FTS_ENT_ARITH, FTS_ENT_SYNC,
                             FTS_ENT_INT} fts_entry_e;
   // reference kinds
   typedef enum logic [1:0] {FTS_ACC_READ, FTS_ACC_WRITE, FTS_ACC_EXEC} fts_access_e;
   // status write sources
   typedef enum logic [1:0] {FTS_PSW_RTI, FTS_PSW_RETSYS, FTS_PSW_SWPIPL} fts_psw_e;
endpackage

// *** tb/fts_unit_monitor.sv ***
// checker for fts_unit: status, dispatch, fault and trap relations at the ports
// assumes it is bound to every fts_unit instance with the same trap count
`timescale 1ns/1ps
module fts_unit_monitor #(
   parameter int NTRAP = 4 // traps reported together
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // watched inputs
   input wire logic ref_valid_i,
   input wire logic ref_kseg_i,
   input wire logic [fts_pkg::VA_W-1:0] ref_pc_i,
   input wire logic [NTRAP-1:0] arith_trap_i,
   input wire logic [NTRAP-1:0] arith_swc_i,
   input wire logic [fts_pkg::VA_W-1:0] next_pc_i,
   input wire logic sync_cause_i,
   input wire logic ps_write_i,
   input wire logic swap_req_i,
   input wire logic [fts_pkg::VA_W-1:0] pcb_addr_i,
   // watched outputs
   input wire logic [fts_pkg::PS_W-1:0] processor_status_o,
   input wire logic dispatch_o,
   input wire fts_pkg::fts_entry_e dispatch_kind_o,
   input wire logic [fts_pkg::VA_W-1:0] exc_pc_o,
   input wire logic [2:0] mm_fault_code_o,
   input wire logic software_completion_summary_o,
   input wire logic [2:0] int_level_o,
   input wire logic use_kernel_stack_o,
   input wire logic issue_hold_o,
   input wire logic swap_busy_o
);
   import fts_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // dispatch kind decodes
   wire mm_d = dispatch_o && dispatch_kind_o == FTS_ENT_MM;
   wire ar_d = dispatch_o && dispatch_kind_o == FTS_ENT_ARITH;
   wire in_d = dispatch_o && dispatch_kind_o == FTS_ENT_INT;
   wire user = processor_status_o[PS_MODE_BIT];
   kernel_entry_a: assert property (dispatch_o |-> !user && use_kernel_stack_o)
      else $error("entry not in kernel mode");
   user_level_a: assert property (user |-> processor_status_o[2:0] == IPL_ZERO)
      else $error("user mode with nonzero level");
   // a status change needs a write one edge earlier or a dispatch in the same cycle
   status_hold_a: assert property (
      !dispatch_o && !$past(ps_write_i) |-> $stable(processor_status_o))
      else $error("status changed without cause");
   int_raise_a: assert property (
      in_d |-> processor_status_o[2:0] == int_level_o &&
      int_level_o > $past(processor_status_o[2:0]))
      else $error("interrupt level not raised");
   int_floor_a: assert property (in_d |-> int_level_o >= IPL_DEV_LO)
      else $error("interrupt level below device range");
   mm_code_a: assert property (mm_d |-> mm_fault_code_o <= FC_FOW)
      else $error("fault code out of range");
   fault_pc_a: assert property (mm_d |-> exc_pc_o == $past(ref_pc_i))
      else $error("fault pc not faulting pc");
   trap_pc_a: assert property (ar_d |-> exc_pc_o == $past(next_pc_i))
      else $error("trap pc not next pc");
   swc_and_a: assert property (
      ar_d |-> software_completion_summary_o == $past(&(arith_swc_i | ~arith_trap_i)))
      else $error("completion summary wrong");
   sync_hold_a: assert property (sync_cause_i && !swap_busy_o |=> issue_hold_o)
      else $error("issue not held for sync trap");
   kseg_user_a: assert property (
      ref_valid_i && ref_kseg_i && user && !swap_busy_o |=> mm_d && mm_fault_code_o == FC_ACV)
      else $error("user direct segment access not refused");
   align_err_a: assert property (
      swap_req_i && pcb_addr_i[2:0] != 3'h0 && !swap_busy_o |=> !swap_busy_o)
      else $error("misaligned swap started");
   swap_hold_a: assert property (swap_busy_o |-> issue_hold_o)
      else $error("issue not held during swap");
endmodule // fts_unit_monitor
bind fts_unit fts_unit_monitor #(.NTRAP(NTRAP)) mon_i (.clk_i, .reset_n_i, .ref_valid_i,
   .ref_kseg_i, .ref_pc_i, .arith_trap_i, .arith_swc_i, .next_pc_i, .sync_cause_i,
   .ps_write_i, .swap_req_i, .pcb_addr_i, .processor_status_o, .dispatch_o, .dispatch_kind_o,
   .exc_pc_o, .mm_fault_code_o, .software_completion_summary_o, .int_level_o,
   .use_kernel_stack_o, .issue_hold_o, .swap_busy_o);

// *** tb/tb_fts_unit.sv ***
// self-checking bench for fts_unit: fault table, traps, status, interrupts, swap
// assumes fts_pkg is compiled first; inputs change on the falling edge
`timescale 1ns/1ps
module tb_fts_unit;
   import fts_pkg::*;
   // one fault case: kind, direct segment, status, three entries, code
   typedef struct {fts_access_e k; logic ks; logic [3:0] ps; logic [15:0] p1, p2, p3;
      logic [2:0] code;} fts_row_s;
   logic clk_i = 0, reset_n_i = 0, ref_valid_i = 0, ref_kseg_i = 0, sync_cause_i = 0;
   logic sync_done_i = 0, ps_write_i = 0, swap_req_i = 0, swap_done_i = 0, got;
   logic [63:0] ref_pc_i = 0, next_pc_i = 0, sync_pc_i = 0, pcb_addr_i = 0, exc_pc_o;
   logic [15:0] pte1_i = 0, pte2_i = 0, pte3_i = 0;
   logic [3:0] arith_trap_i = 0, arith_swc_i = 0, ps_wdata_i = 0, processor_status_o;
   logic [4:0] irq = 0; // io low, io high, clock, perf, machine check
   logic [2:0] mm_fault_code_o, int_level_o;
   logic dispatch_o, software_completion_summary_o, use_kernel_stack_o, issue_hold_o;
   logic swap_busy_o, swap_align_err_o;
   fts_access_e ref_kind_i = FTS_ACC_READ;
   fts_psw_e ps_src_i = FTS_PSW_RTI;
   fts_entry_e dispatch_kind_o;
   int num_errors = 0, num_checks = 0;
   fts_row_s rows [13] = '{
      '{FTS_ACC_READ, 1'b0, 4'h7, 16'h0000, 16'h0101, 16'h3301, FC_ACV},
      '{FTS_ACC_READ, 1'b0, 4'h7, 16'h0100, 16'h0101, 16'h3301, FC_TNV},
      '{FTS_ACC_READ, 1'b0, 4'h7, 16'h0101, 16'h0000, 16'h3301, FC_ACV},
      '{FTS_ACC_WRITE, 1'b0, 4'h7, 16'h0101, 16'h0100, 16'h3301, FC_TNV},
      '{FTS_ACC_READ, 1'b0, 4'h8, 16'h0101, 16'h0101, 16'h3101, FC_ACV},
      '{FTS_ACC_WRITE, 1'b0, 4'h8, 16'h0101, 16'h0101, 16'h1301, FC_ACV},
      '{FTS_ACC_WRITE, 1'b0, 4'h7, 16'h0101, 16'h0101, 16'h2301, FC_ACV},
      '{FTS_ACC_READ, 1'b0, 4'h7, 16'h0101, 16'h0101, 16'h3300, FC_TNV},
      '{FTS_ACC_WRITE, 1'b0, 4'h7, 16'h0101, 16'h0101, 16'h3305, FC_FOW},
      '{FTS_ACC_READ, 1'b0, 4'h7, 16'h0101, 16'h0101, 16'h3303, FC_FOR},
      '{FTS_ACC_EXEC, 1'b0, 4'h7, 16'h0101, 16'h0101, 16'h3309, FC_FOE},
      '{FTS_ACC_READ, 1'b1, 4'h8, 16'h0000, 16'h0000, 16'h0000, FC_ACV},
      '{FTS_ACC_READ, 1'b0, 4'h7, 16'h0001, 16'h0001, 16'h3303, FC_FOR}};
   fts_unit #(.NTRAP(4)) uut (.clk_i, .reset_n_i, .ref_valid_i, .ref_kind_i, .ref_kseg_i,
      .ref_pc_i, .pte1_i, .pte2_i, .pte3_i, .arith_trap_i, .arith_swc_i, .next_pc_i,
      .sync_cause_i, .sync_done_i, .sync_pc_i, .io_lo_req_i(irq[0]), .io_hi_req_i(irq[1]),
      .clock_req_i(irq[2]), .perf_req_i(irq[3]), .mchk_req_i(irq[4]), .ps_write_i, .ps_src_i,
      .ps_wdata_i, .swap_req_i, .pcb_addr_i, .swap_done_i, .processor_status_o, .dispatch_o,
      .dispatch_kind_o, .exc_pc_o, .mm_fault_code_o, .software_completion_summary_o,
      .int_level_o, .use_kernel_stack_o, .issue_hold_o, .swap_busy_o, .swap_align_err_o);
   // 40 mhz core clock
   always #12.5 clk_i = ~clk_i;
   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got_v);
      num_checks++;
      if (got_v !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got_v);
      end
   endtask
   // leading edge skipped so the write never lands in a dispatch cycle
   task automatic set_ps(input fts_psw_e src, input logic [3:0] v);
      @(negedge clk_i);
      ps_write_i = 1'b1;
      ps_src_i = src;
      ps_wdata_i = v;
      @(negedge clk_i);
      ps_write_i = 1'b0;
   endtask
   task automatic do_ref(input fts_row_s r, input logic [63:0] pc);
      ref_kind_i = r.k;
      ref_kseg_i = r.ks;
      pte1_i = r.p1;
      pte2_i = r.p2;
      pte3_i = r.p3;
      ref_pc_i = pc;
      ref_valid_i = 1'b1;
      @(negedge clk_i);
      ref_valid_i = 1'b0;
   endtask
   // bounded wait; looks first, since the pulse may already stand
   task automatic wait_disp(input int n, output logic g);
      for (int j = 0; j < n && dispatch_o !== 1'b1; j++) @(negedge clk_i);
      g = (dispatch_o === 1'b1);
   endtask
   task automatic pulse_swap(input logic [63:0] a);
      pcb_addr_i = a;
      swap_req_i = 1'b1;
      @(negedge clk_i);
      swap_req_i = 1'b0;
      @(negedge clk_i);
   endtask
   task automatic results();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (5) @(negedge clk_i);
      chk("reset ps", PS_RESET, processor_status_o);
      chk("reset stack", 1, use_kernel_stack_o);
      chk("reset kind", FTS_ENT_NONE, dispatch_kind_o);
      reset_n_i = 1'b1;
      foreach (rows[i]) begin
         set_ps(FTS_PSW_RTI, rows[i].ps);
         do_ref(rows[i], 64'h1000 + 64'(i));
         wait_disp(3, got);
         chk("mm taken", 1, got);
         chk("mm kind", FTS_ENT_MM, dispatch_kind_o);
         chk("mm code", rows[i].code, mm_fault_code_o);
         chk("mm pc", 64'h1000 + 64'(i), exc_pc_o);
         chk("mm ps", rows[i].ps & 4'h7, processor_status_o);
      end
      next_pc_i = 64'h2000;
      arith_swc_i = 4'h7;
      for (int t = 0; t < 2; t++) begin
         arith_trap_i = t ? 4'hf : 4'h5;
         @(negedge clk_i);
         arith_trap_i = 4'h0;
         wait_disp(3, got);
         chk("trap kind", FTS_ENT_ARITH, dispatch_kind_o);
         chk("trap pc", 64'h2000, exc_pc_o);
         chk("trap swc", t == 0, software_completion_summary_o);
         @(negedge clk_i);
      end
      // a fault and an arithmetic trap in one cycle: the fault wins, the trap is lost
      arith_trap_i = 4'h1;
      do_ref(rows[9], 64'h6000);
      arith_trap_i = 4'h0;
      chk("order kind", FTS_ENT_MM, dispatch_kind_o);
      chk("order pc", 64'h6000, exc_pc_o);
      chk("order code", FC_FOR, mm_fault_code_o);
      chk("order swc", 0, software_completion_summary_o);
      @(negedge clk_i);
      sync_pc_i = 64'h3000;
      sync_cause_i = 1'b1;
      @(negedge clk_i);
      sync_cause_i = 1'b0;
      chk("hold set", 1, issue_hold_o);
      repeat (3) @(negedge clk_i);
      chk("hold kept", 1, issue_hold_o);
      sync_done_i = 1'b1;
      @(negedge clk_i);
      sync_done_i = 1'b0;
      wait_disp(3, got);
      chk("sync kind", FTS_ENT_SYNC, dispatch_kind_o);
      chk("sync pc", 64'h3000, exc_pc_o);
      chk("hold clear", 0, issue_hold_o);
      // a new cause in the cycle the pending trap is taken keeps issue held
      sync_cause_i = 1'b1;
      @(negedge clk_i);
      sync_done_i = 1'b1;
      @(negedge clk_i);
      sync_cause_i = 1'b0;
      chk("sync again", FTS_ENT_SYNC, dispatch_kind_o);
      chk("set wins", 1, issue_hold_o);
      @(negedge clk_i);
      sync_done_i = 1'b0;
      chk("sync last", FTS_ENT_SYNC, dispatch_kind_o);
      chk("hold drop", 0, issue_hold_o);
      set_ps(FTS_PSW_RTI, 4'hf);
      chk("user ps", 4'h8, processor_status_o);
      chk("user stack", 0, use_kernel_stack_o);
      set_ps(FTS_PSW_RETSYS, 4'h2);
      chk("retsys ps", 4'h2, processor_status_o);
      set_ps(FTS_PSW_SWPIPL, 4'hd);
      chk("swpipl ps", 4'h5, processor_status_o);
      // each class held off at its own level, then taken one level lower
      for (int s = 0; s < 5; s++) begin
         set_ps(FTS_PSW_SWPIPL, 4'(s + 3));
         irq[s] = 1'b1;
         wait_disp(6, got);
         chk("int held", 0, got);
         set_ps(FTS_PSW_SWPIPL, 4'(s + 2));
         wait_disp(6, got);
         chk("int kind", FTS_ENT_INT, dispatch_kind_o);
         chk("int level", s + 3, int_level_o);
         chk("int ps", s + 3, processor_status_o);
         irq[s] = 1'b0;
         repeat (4) @(negedge clk_i);
      end
      pulse_swap(64'h44);
      chk("align err", 1, swap_align_err_o);
      chk("no start", 0, swap_busy_o);
      pulse_swap(64'h40);
      chk("swap busy", 1, swap_busy_o);
      chk("err cleared", 0, swap_align_err_o);
      do_ref(rows[0], 64'h4000);
      wait_disp(3, got);
      chk("busy refused", 0, got);
      swap_done_i = 1'b1;
      @(negedge clk_i);
      swap_done_i = 1'b0;
      @(negedge clk_i);
      chk("swap end", 0, swap_busy_o);
      // reset in mid-run returns the status to kernel at level seven
      set_ps(FTS_PSW_RTI, 4'h8);
      reset_n_i = 1'b0;
      @(negedge clk_i);
      chk("rerun ps", PS_RESET, processor_status_o);
      chk("rerun code", FC_TNV, mm_fault_code_o);
      chk("rerun hold", 0, issue_hold_o);
      reset_n_i = 1'b1;
      do_ref(rows[0], 64'h5000);
      wait_disp(3, got);
      chk("rerun taken", 1, got);
      chk("rerun fault", FC_ACV, mm_fault_code_o);
      chk("rerun pc", 64'h5000, exc_pc_o);
      results();
   end
   // the run needs some 150 cycles; 3000 leaves room for slow answers
   initial begin
      #75000;
      num_errors++;
      results();
   end
endmodule // tb_fts_unit
